// ### rtl/ms_tick_divider.sv
// Millisecond tick divider producing a one-cycle enable
`timescale 1ns/10ps
module ms_tick_divider #(
    parameter int DIV = 20000                 // Cycles per tick
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    output logic      tick
);
    logic [31:0] cnt_q;                       // Cycle counter

    // Count up from one: first tick lines up with pin registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 32'h1;
            tick  <= 1'b0;
        end else if (cnt_q >= 32'(DIV - 1)) begin
            cnt_q <= 32'h0;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h1;
            tick  <= 1'b0;
        end
    end
endmodule : ms_tick_divider

// ### rtl/pack_presence_fault_monitor.sv
// Pack presence, sleep entry and safety output control with AXI4-Lite registers
// Functional notes
// - Active: 5 ms pull-up per 250 ms
// - Presence decided from four-sample average, from each single pulse in sleep
// - Sleep: pulse at configurable sleep period
// - Idle: pull-down on, pull-up off
// - Bus lines low: calibrate, then sleep
// - Fuse drive on criterion violation or command
// - Fuse pin read back as protector status
// - Thermistor trip latched until power-on reset
// - Per-thermistor pull-up enable under firmware
// - Precharge gate for low voltage/temperature
// - Three LED constant-current sink enables
`timescale 1ns/10ps
module pack_presence_fault_monitor
    import pack_monitor_pkg::*;
#(
    parameter int MS_DIV   = pack_monitor_pkg::MS_CYCLES, // Cycles per millisecond
    parameter int N_THERM  = 4,                           // Thermistor inputs
    parameter int N_LED    = 3,                           // LED sinks
    parameter int N_CRIT   = 8                            // Permanent criteria
) (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // AXI4-Lite slave
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // Pack pins
    input  wire logic               pack_present_n,
    output logic                    presence_pullup_on,
    output logic                    presence_pulldown_on,
    input  wire logic               bus_clk_in,
    input  wire logic               bus_data_in,
    input  wire logic [N_CRIT-1:0]  crit_violation,
    output logic                    analog_fuse_out,
    output logic                    analog_fuse_oe_n,
    input  wire logic               analog_fuse_in,
    input  wire logic               safety_thermistor_sense,
    output logic                    safety_thermistor_enable,
    output logic [N_THERM-1:0]      thermistor_drive,
    input  wire logic               low_batt_or_temp,
    output logic                    precharge_gate,
    output logic [N_LED-1:0]        led_sink,
    input  wire logic               display_request_n,
    output logic                    irq
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic               ms_tick;             // One-millisecond enable
    mode_e              mode_q;              // Power mode
    logic [15:0]        ms_cnt_q;            // Millisecond phase in interval
    logic [15:0]        sleep_per_q;         // Sleep sampling period
    pin_drive_s         drv;                 // Presence drive decode
    logic [2:0]         low_sum_q;           // Low samples in current group
    logic [1:0]         grp_cnt_q;           // Samples taken in group
    logic               present_q;           // Presence, averaged outside sleep
    logic [EV_W-1:0]    ev_stat_q;           // Sticky events
    logic [EV_W-1:0]    ev_mask_q;           // Event mask
    logic [EV_W-1:0]    ev_set;              // Event pulses this cycle
    logic [3:0]         ctrl_q;              // Control bits
    logic [N_THERM-1:0] therm_en_q;          // Thermistor pull-up enables
    logic [N_LED-1:0]   led_en_q;            // LED enables
    logic [N_CRIT-1:0]  crit_en_q;           // Criterion enables
    logic               fuse_q;              // Fuse drive latch
    logic               therm_trip_q;        // Thermistor fault latch
    logic               sec_prot_q;          // Protector state seen
    logic [7:0]         aw_addr_q;           // Captured write address
    logic               aw_have_q;           // Write address held
    logic [31:0]        w_data_q;            // Captured write data
    logic               w_have_q;            // Write data held
    logic               wr_fire;             // Write commits this cycle
    logic [31:0]        rd_word;             // Read mux
    logic               inst_chg;            // Presence changed pulse
    logic [15:0]        per_ms;              // Current interval

    // ****************************************************************
    // Millisecond timebase
    // ****************************************************************
    ms_tick_divider #(
        .DIV (MS_DIV)
    ) u_ms (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (ms_tick)
    );

    // ****************************************************************
    // Presence pulse sequencing
    // ****************************************************************
    // Interval depends on mode; sleep uses the software period
    assign per_ms = (mode_q == MODE_SLEEP) ? sleep_per_q : 16'(ACTIVE_PER_MS);

    // Pulse phase; calibration lets a pulse end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ms_cnt_q <= 16'h0;
        end else if (mode_q == MODE_CAL && ms_cnt_q >= 16'(PULSE_MS)) begin
            ms_cnt_q <= 16'(PULSE_MS);
        end else if (ms_tick) begin
            // Wrap; a period shorter than the pulse still gives a full pulse
            if (ms_cnt_q + 16'h1 >= per_ms && ms_cnt_q + 16'h1 >= 16'(PULSE_MS)) begin
                ms_cnt_q <= 16'h0;
            end else begin
                ms_cnt_q <= ms_cnt_q + 16'h1;
            end
        end
    end

    // Pull-up during the first 5 ms, pull-down otherwise
    always_comb begin
        drv.pullup_on   = ms_cnt_q < 16'(PULSE_MS);
        drv.pulldown_on = !drv.pullup_on;
        // Sample in the last cycle before the pull-up goes away
        drv.sample      = drv.pullup_on && ms_tick
                          && (ms_cnt_q == 16'(PULSE_MS - 1));
    end

    // Registered pin drives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            presence_pullup_on   <= 1'b0;
            presence_pulldown_on <= 1'b1;
        end else begin
            presence_pullup_on   <= drv.pullup_on;
            presence_pulldown_on <= drv.pulldown_on;
        end
    end

    // ****************************************************************
    // Presence averaging
    // ****************************************************************
    // A low sample means present
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low_sum_q <= 3'h0;
            grp_cnt_q <= 2'h0;
            present_q <= 1'b0;
            inst_chg  <= 1'b0;
        end else begin
            inst_chg <= 1'b0;
            if (drv.sample) begin
                if (mode_q == MODE_SLEEP) begin
                    // Sleep decides from each single pulse
                    present_q <= !pack_present_n;
                    inst_chg  <= (present_q == pack_present_n);
                    low_sum_q <= 3'h0;
                    grp_cnt_q <= 2'h0;
                end else if (grp_cnt_q == 2'(AVG_SAMPLES - 1)) begin
                    // Average of four: majority low, tie counts as low
                    present_q <= (low_sum_q + 3'(!pack_present_n)) >= 3'h2;
                    inst_chg  <= present_q !=
                                 ((low_sum_q + 3'(!pack_present_n)) >= 3'h2);
                    low_sum_q <= 3'h0;
                    grp_cnt_q <= 2'h0;
                end else begin
                    low_sum_q <= low_sum_q + 3'(!pack_present_n);
                    grp_cnt_q <= grp_cnt_q + 2'h1;
                end
            end
        end
    end

    // ****************************************************************
    // Power mode
    // ****************************************************************
    // Bus lines low: calibrate, then sleep
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= MODE_ACTIVE;
        end else begin
            unique case (mode_q)
                MODE_ACTIVE: begin
                    if (!bus_clk_in && !bus_data_in) begin
                        mode_q <= MODE_CAL;
                    end
                end
                MODE_CAL: begin
                    // Sleep only after firmware reports calibration done
                    if (ctrl_q[CTRL_CAL_DONE_BIT]) begin
                        mode_q <= MODE_SLEEP;
                    end
                end
                MODE_SLEEP: begin
                    if (bus_clk_in || bus_data_in || ctrl_q[CTRL_WAKE_BIT]) begin
                        mode_q <= MODE_ACTIVE;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Safety latches and outputs
    // ****************************************************************
    // Fuse and thermistor faults hold until the power-on reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fuse_q       <= 1'b0;
            therm_trip_q <= 1'b0;
            sec_prot_q   <= 1'b0;
        end else begin
            if (|(crit_violation & crit_en_q) || ctrl_q[CTRL_FUSE_CMD_BIT]) begin
                fuse_q <= 1'b1;
            end
            if (safety_thermistor_sense) begin
                therm_trip_q <= 1'b1;
            end
            // Pin shows the protector only while undriven
            sec_prot_q <= analog_fuse_in && !fuse_q;
        end
    end

    // Registered pin outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            analog_fuse_out          <= 1'b0;
            analog_fuse_oe_n         <= 1'b1;
            safety_thermistor_enable <= 1'b0;
            thermistor_drive         <= '0;
            precharge_gate           <= 1'b0;
            led_sink                 <= '0;
        end else begin
            analog_fuse_out          <= fuse_q;
            analog_fuse_oe_n         <= !fuse_q;
            safety_thermistor_enable <= 1'b1;
            thermistor_drive         <= therm_en_q;
            precharge_gate <= ctrl_q[CTRL_PRECHG_BIT] && low_batt_or_temp;
            // Sinks on only while display requested
            led_sink <= display_request_n ? '0 : led_en_q;
        end
    end

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    assign ev_set[EV_INST_CHG] = inst_chg;
    assign ev_set[EV_SLEEP]    = (mode_q == MODE_CAL) && ctrl_q[CTRL_CAL_DONE_BIT];
    assign ev_set[EV_CAL_REQ]  = (mode_q == MODE_ACTIVE) && !bus_clk_in && !bus_data_in;
    assign ev_set[EV_FUSE]     = |(crit_violation & crit_en_q) || ctrl_q[CTRL_FUSE_CMD_BIT];
    assign ev_set[EV_SEC_PROT] = analog_fuse_in && !fuse_q;
    assign ev_set[EV_THERM]    = safety_thermistor_sense;

    // Sticky status; set wins over write-one-clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ev_stat_q <= '0;
            irq       <= 1'b0;
        end else begin
            if (wr_fire && aw_addr_q == IRQ_STAT_OFS) begin
                ev_stat_q <= (ev_stat_q & ~w_data_q[EV_W-1:0]) | ev_set;
            end else begin
                ev_stat_q <= ev_stat_q | ev_set;
            end
            irq <= |(ev_stat_q & ev_mask_q);
        end
    end

    // ****************************************************************
    // AXI4-Lite write path
    // ****************************************************************
    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

    // Take address and data in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
        end else begin
            s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                           {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // Unmapped address gets SLVERR
                s_axi_bresp  <= (aw_addr_q > CRIT_OFS || aw_addr_q[1:0] != 2'h0)
                                ? 2'h2 : 2'h0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q      <= 4'h0;
            ev_mask_q   <= '0;
            sleep_per_q <= SLEEP_PER_RST;
            therm_en_q  <= '0;
            led_en_q    <= '0;
            crit_en_q   <= '0;
        end else if (wr_fire) begin
            unique case (aw_addr_q)
                CTRL_OFS:      ctrl_q      <= w_data_q[3:0];
                IRQ_MASK_OFS:  ev_mask_q   <= w_data_q[EV_W-1:0];
                SLEEP_PER_OFS: sleep_per_q <= w_data_q[15:0];
                THERM_OFS:     therm_en_q  <= w_data_q[N_THERM-1:0];
                LED_OFS:       led_en_q    <= w_data_q[N_LED-1:0];
                CRIT_OFS:      crit_en_q   <= w_data_q[N_CRIT-1:0];
                default:       ;
            endcase
        end else if (mode_q == MODE_SLEEP) begin
            // Calibration-done and wake are one-shot handshakes
            ctrl_q[CTRL_CAL_DONE_BIT] <= 1'b0;
            ctrl_q[CTRL_WAKE_BIT]     <= 1'b0;
        end
    end

    // ****************************************************************
    // AXI4-Lite read path
    // ****************************************************************
    always_comb begin
        rd_word = 32'h0;
        unique case (s_axi_araddr)
            CTRL_OFS:      rd_word[3:0]         = ctrl_q;
            STATUS_OFS:    rd_word[7:0]         = {1'b0, mode_q == MODE_SLEEP,
                                                   therm_trip_q, sec_prot_q, fuse_q,
                                                   mode_q == MODE_CAL, present_q,
                                                   presence_pullup_on};
            IRQ_STAT_OFS:  rd_word[EV_W-1:0]    = ev_stat_q;
            IRQ_MASK_OFS:  rd_word[EV_W-1:0]    = ev_mask_q;
            SLEEP_PER_OFS: rd_word[15:0]        = sleep_per_q;
            THERM_OFS:     rd_word[N_THERM-1:0] = therm_en_q;
            LED_OFS:       rd_word[N_LED-1:0]   = led_en_q;
            CRIT_OFS:      rd_word[N_CRIT-1:0]  = crit_en_q;
            default:       rd_word              = 32'h0;
        endcase
    end

    // Address accepted and answered one cycle later
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_word;
                s_axi_rresp   <= (s_axi_araddr > CRIT_OFS || s_axi_araddr[1:0] != 2'h0)
                                 ? 2'h2 : 2'h0;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule : pack_presence_fault_monitor

// ### shared/pack_monitor_pkg.sv
// Package of constants, register map and carrier types for the pack monitor
package pack_monitor_pkg;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] CTRL_OFS      = 8'h00; // Mode and command bits
    localparam logic [7:0] STATUS_OFS    = 8'h04; // Live state, read only
    localparam logic [7:0] IRQ_STAT_OFS  = 8'h08; // Sticky events, write one to clear
    localparam logic [7:0] IRQ_MASK_OFS  = 8'h0C; // Interrupt enables
    localparam logic [7:0] SLEEP_PER_OFS = 8'h10; // Sleep sampling period in ms
    localparam logic [7:0] THERM_OFS     = 8'h14; // Thermistor pull-up enables
    localparam logic [7:0] LED_OFS       = 8'h18; // LED sink enables
    localparam logic [7:0] CRIT_OFS      = 8'h1C; // Permanent criterion enables

    // ****************************************************************
    // Control register fields
    // ****************************************************************
    localparam int CTRL_FUSE_CMD_BIT = 0;  // Command fuse blow, sticky until reset
    localparam int CTRL_PRECHG_BIT   = 1;  // Precharge path request
    localparam int CTRL_CAL_DONE_BIT = 2;  // Firmware signals offset calibration done
    localparam int CTRL_WAKE_BIT     = 3;  // Force return to active mode

    // ****************************************************************
    // Status and event fields
    // ****************************************************************
    localparam int EV_INST_CHG  = 0;       // Presence changed, averaged outside sleep
    localparam int EV_SLEEP     = 1;       // Entered sleep
    localparam int EV_CAL_REQ   = 2;       // Bus lines low, calibration wanted
    localparam int EV_FUSE      = 3;       // Fuse drive asserted
    localparam int EV_SEC_PROT  = 4;       // Secondary protector fired
    localparam int EV_THERM     = 5;       // Safety thermistor trip latched
    localparam int EV_W         = 6;

    // ****************************************************************
    // Reset values and timing
    // ****************************************************************
    localparam logic [15:0] SLEEP_PER_RST = 16'h03E8; // 1000 ms
    localparam int CLK_HZ          = 20_000_000;
    localparam int MS_CYCLES       = CLK_HZ / 1000;   // Cycles in one millisecond
    localparam int ACTIVE_PER_MS   = 250;             // Active pulse interval
    localparam int PULSE_MS        = 5;               // Pull-up pulse length
    localparam int AVG_SAMPLES     = 4;               // Presence samples averaged

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {MODE_ACTIVE, MODE_CAL, MODE_SLEEP} mode_e;

    typedef struct packed {
        logic pullup_on;    // Presence pull-up drive
        logic pulldown_on;  // Presence pull-down drive
        logic sample;       // One-cycle sample strobe
    } pin_drive_s;

endpackage : pack_monitor_pkg

// ### tb/host_side_model.sv
// Host and pack board model behind the presence and fuse pins
`timescale 1ns/10ps
module host_side_model (
    input  logic installed,          // Pack seated in the host
    input  logic prot_fired,         // Secondary protector output
    input  logic presence_pullup_on,
    input  logic analog_fuse_out,
    input  logic analog_fuse_oe_n,
    output logic pack_present_n,
    output logic analog_fuse_in
);
    // Host grounds the pin; loose, it follows the device's own pull
    assign pack_present_n = installed ? 1'b0 : presence_pullup_on;
    // Pin shows the device drive, otherwise the protector level
    assign analog_fuse_in = !analog_fuse_oe_n ? analog_fuse_out : prot_fired;
endmodule : host_side_model

// ### tb/pack_monitor_checker.sv
// Port-level checker for the pack presence and fault monitor
`timescale 1ns/10ps
module pack_monitor_checker #(
    parameter int MS_DIV = 20000      // Cycles per millisecond
) (
    input logic        aclk,
    input logic        aresetn,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    input logic        presence_pullup_on,
    input logic        presence_pulldown_on,
    input logic        analog_fuse_out,
    input logic        analog_fuse_oe_n,
    input logic        low_batt_or_temp,
    input logic        precharge_gate,
    input logic [2:0]  led_sink,
    input logic        display_request_n
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [31:0] high_q; // Cycles the pull-up has been on
    always_ff @(posedge aclk) begin
        high_q <= (!aresetn || !presence_pullup_on) ? '0 : high_q + 1;
    end
    // Answers waiting on the master
    sequence s_b_wait; s_axi_bvalid && !s_axi_bready; endsequence
    sequence s_r_wait; s_axi_rvalid && !s_axi_rready; endsequence
    a_pull_exclusive: assert property (presence_pullup_on != presence_pulldown_on)
        else $error("pull drives overlap");
    a_pulse_length: assert property ($fell(presence_pullup_on) |-> high_q == 5*MS_DIV)
        else $error("test pulse length wrong");
    a_fuse_sticky: assert property (analog_fuse_out |=> analog_fuse_out)
        else $error("fuse drive released");
    a_fuse_drives: assert property (analog_fuse_out |-> !analog_fuse_oe_n)
        else $error("fuse driven without enable");
    a_prechg_cause: assert property (precharge_gate |-> $past(low_batt_or_temp))
        else $error("precharge without cause");
    a_led_gated: assert property (led_sink != 0 |-> !$past(display_request_n))
        else $error("led on without request");
    a_bresp_hold: assert property (s_b_wait |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    a_rdata_hold: assert property (s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer changed early");
endmodule : pack_monitor_checker
bind pack_presence_fault_monitor pack_monitor_checker #(.MS_DIV(MS_DIV)) chk_i (.*);

// ### tb/pack_presence_fault_monitor_tb_top.sv
// Self-checking bench for the pack presence and fault monitor
`timescale 1ns/10ps
module pack_presence_fault_monitor_tb_top;
    import pack_monitor_pkg::*;
    localparam int MS_DIV = 10; // Short millisecond
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, bus_clk_in = 1, bus_data_in = 1, irq;
    logic low_batt_or_temp = 0, display_request_n = 1, safety_thermistor_sense = 0;
    logic installed = 0, prot_fired = 0, pack_present_n, analog_fuse_in, precharge_gate;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic presence_pullup_on, presence_pulldown_on, analog_fuse_out, analog_fuse_oe_n;
    logic safety_thermistor_enable;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, crit_violation = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rnd = 32'hACC7, msk_q[$];
    logic [3:0]  s_axi_wstrb = 4'hF, thermistor_drive;
    logic [2:0]  led_sink;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [33:0] exp_q[$]; // Expected resp and data
    int          bad_count = 0, checks = 0;
    always #25 aclk = ~aclk;
    pack_presence_fault_monitor #(.MS_DIV(MS_DIV)) uut (.*);
    host_side_model host (.installed, .prot_fired, .presence_pullup_on, .analog_fuse_out,
        .analog_fuse_oe_n, .pack_present_n, .analog_fuse_in);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        chk("bresp", s_axi_bresp, 0);
        s_axi_bready <= 0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [31:0] m);
        @(posedge aclk);
        exp_q.push_back(e);
        msk_q.push_back(m);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 0;
    endtask : rd
    // Read answers against the oldest note
    always @(posedge aclk) if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0)
        chk("read", {s_axi_rresp, s_axi_rdata & msk_q.pop_front()}, exp_q.pop_front());
    task automatic complete_run;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run
    initial begin
        cyc(60000);
        bad_count++;
        complete_run();
    end
    initial begin
        cyc(20);
        aresetn <= 1;
        rd(SLEEP_PER_OFS, {18'h0, SLEEP_PER_RST}, 32'hFFFF);
        rd(8'h20, {2'b10, 32'h0}, 32'hFFFFFFFF);
        installed <= 1;
        cyc(13000);
        rd(STATUS_OFS, 34'h2, 32'h2);
        wr(IRQ_MASK_OFS, 32'h1);
        cyc(3);
        chk("irq set", irq, 1);
        wr(IRQ_STAT_OFS, 32'h1);
        cyc(3);
        chk("irq clear", irq, 0);
        for (int i = 0; i < 3; i++) begin
            rnd = lfsr(rnd);
            wr(THERM_OFS, rnd & 32'hF);
            cyc(3);
            chk("therm", thermistor_drive, rnd[3:0]);
        end
        wr(LED_OFS, 32'h5);
        display_request_n <= 0;
        cyc(3);
        chk("led on", led_sink, 3'h5);
        display_request_n <= 1;
        low_batt_or_temp <= 1;
        wr(CTRL_OFS, 32'h2);
        cyc(3);
        chk("led off", led_sink, 3'h0);
        chk("precharge", precharge_gate, 1);
        chk("sense enable", safety_thermistor_enable, 1);
        safety_thermistor_sense <= 1;
        prot_fired <= 1;
        cyc(3);
        safety_thermistor_sense <= 0;
        cyc(3);
        rd(STATUS_OFS, 34'h30, 32'h30);
        wr(CRIT_OFS, 32'h4);
        crit_violation <= 8'h04;
        cyc(3);
        crit_violation <= 8'h00;
        cyc(3);
        chk("fuse", {analog_fuse_out, analog_fuse_oe_n}, 2'b10);
        wr(SLEEP_PER_OFS, 32'h8);
        bus_clk_in <= 0;
        bus_data_in <= 0;
        cyc(5);
        rd(STATUS_OFS, 34'h4, 32'h44);
        wr(CTRL_OFS, 32'h6);
        cyc(5);
        rd(STATUS_OFS, 34'h40, 32'h44);
        cyc(1000);
        complete_run();
    end
endmodule : pack_presence_fault_monitor_tb_top
